// *** iso_irq_pkg.sv ***
// iso_irq_pkg: register map, field widths and reset values for the
// isochronous context interrupt event/mask block.
// assumes a 32-bit AHB-Lite register bus, word aligned.
package iso_irq_pkg;

  localparam int unsigned TX_CTX_N = 8;
  localparam int unsigned RX_CTX_N = 4;

  localparam logic [7:0] TX_EVENT_SET_OFS   = 8'h90;
  localparam logic [7:0] TX_EVENT_CLEAR_OFS = 8'h94;
  localparam logic [7:0] TX_MASK_SET_OFS    = 8'h98;
  localparam logic [7:0] TX_MASK_CLEAR_OFS  = 8'h9c;
  localparam logic [7:0] RX_EVENT_SET_OFS   = 8'ha0;
  localparam logic [7:0] RX_EVENT_CLEAR_OFS = 8'ha4;
  localparam logic [7:0] RX_MASK_SET_OFS    = 8'ha8;
  localparam logic [7:0] RX_MASK_CLEAR_OFS  = 8'hac;
  // summary control word: bit 31 global gate, bits 7/6 summary masks
  localparam logic [7:0] SUMMARY_CTRL_OFS   = 8'hc0;
  // summary status: raw summary bits at 7/6, read only
  localparam logic [7:0] SUMMARY_STAT_OFS   = 8'hc4;

  localparam int unsigned TX_SUMMARY_BIT = 6;
  localparam int unsigned RX_SUMMARY_BIT = 7;
  localparam int unsigned GLOBAL_GATE_BIT = 31;

  localparam logic [7:0]  TX_EVENT_RST = 8'h00;
  localparam logic [3:0]  RX_EVENT_RST = 4'h0;
  localparam logic [7:0]  TX_MASK_RST  = 8'h00;
  localparam logic [3:0]  RX_MASK_RST  = 4'h0;
  localparam logic [31:0] CTRL_RST     = 32'h0000_0000;

  localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
  localparam logic [1:0] HTRANS_SEQ    = 2'b11;
  localparam logic [2:0] HSIZE_WORD    = 3'b010;

endpackage : iso_irq_pkg

// *** iso_context_irq_event_mask.sv ***
// iso_context_irq_event_mask: per-context isochronous interrupt event and
// mask registers behind an AHB-Lite slave, with summary and irq output.
// assumes the context interrupt lines come from logic on clk.
//
// The AHB-Lite register port is this design's own decision.
`timescale 1ns/10ps

// Notes on behaviour
// - tx context event sets on completed output-last command with interrupt enabled
// - rx context event sets on completed input command with interrupt enabled
// - event bit sets on rising edge of context line or set-address write of one
// - event bit clears only by writing one at clear address; zeros ignored
// - tx event holds bits 7..0; bits 31..8 read zero
// - rx event holds bits 3..0; bits 31..4 read zero
// - tx event bit n marks context n as cause of tx summary (bit 6)
// - rx event bit n marks context n as cause of rx summary (bit 7)
// - tx event at 90h set, 94h clear; clear read gives event AND mask
// - rx event at a0h set, a4h clear; clear read gives event AND mask
// - tx mask at 98h set, 9ch clear; both read raw mask
// - tx mask enables event bit for bit; set and clear by writing ones
// - tx summary reaches irq only when its summary mask bit is one
// - no irq at all unless global gate bit 31 is one
module iso_context_irq_event_mask
  import iso_irq_pkg::*;
(
  input  wire logic                clk,           // 125 MHz clock
  input  wire logic                arst_n,        // async reset, active low
  input  wire logic                hsel,          // slave select
  input  wire logic [31:0]         haddr,         // byte address
  input  wire logic [1:0]          htrans,        // transfer type
  input  wire logic                hwrite,        // write when high
  input  wire logic [2:0]          hsize,         // transfer size
  input  wire logic [31:0]         hwdata,        // write data
  input  wire logic                hready,        // bus ready in
  output logic      [31:0]         hrdata,        // read data
  output logic                     hreadyout,     // always ready
  output logic                     hresp,         // always okay
  input  wire logic [TX_CTX_N-1:0] tx_ctx_irq,    // tx context done lines
  input  wire logic [RX_CTX_N-1:0] rx_ctx_irq,    // rx context done lines
  output logic                     tx_summary_irq, // any masked tx event
  output logic                     rx_summary_irq, // any masked rx event
  output logic                     irq            // level interrupt out
);

  logic [TX_CTX_N-1:0] tx_event_q, tx_event_d;
  logic [RX_CTX_N-1:0] rx_event_q, rx_event_d;
  logic [TX_CTX_N-1:0] tx_mask_q, tx_mask_d;
  logic [RX_CTX_N-1:0] rx_mask_q, rx_mask_d;
  logic [TX_CTX_N-1:0] tx_line_q;
  logic [RX_CTX_N-1:0] rx_line_q;
  logic                gate_q, gate_d;
  logic                tx_sum_en_q, tx_sum_en_d;
  logic                rx_sum_en_q, rx_sum_en_d;
  logic                wr_pend_q;
  logic [7:0]          wr_addr_q;
  logic [31:0]         hrdata_q;

  // write one to set: a set bit wins over a clear bit in the same cycle, so a
  // context edge that meets a software clear is never lost
  function automatic logic [TX_CTX_N-1:0] tx_w1_update(
    input logic [TX_CTX_N-1:0] cur,
    input logic [TX_CTX_N-1:0] set_bits,
    input logic [TX_CTX_N-1:0] clr_bits
  );
    return (cur & ~clr_bits) | set_bits;
  endfunction

  // same update for the narrower receive registers
  function automatic logic [RX_CTX_N-1:0] rx_w1_update(
    input logic [RX_CTX_N-1:0] cur,
    input logic [RX_CTX_N-1:0] set_bits,
    input logic [RX_CTX_N-1:0] clr_bits
  );
    return (cur & ~clr_bits) | set_bits;
  endfunction

  // a data-phase write aimed at one register offset
  function automatic logic wr_hit(
    input logic       pend,
    input logic [7:0] ofs_q,
    input logic [7:0] ofs
  );
    return pend && (ofs_q == ofs);
  endfunction

  // summary control and status words share one bit layout
  function automatic logic [31:0] summary_word(
    input logic top_bit,
    input logic rx_bit,
    input logic tx_bit
  );
    logic [31:0] w;
    w                  = 32'h0000_0000;
    w[GLOBAL_GATE_BIT] = top_bit;
    w[RX_SUMMARY_BIT]  = rx_bit;
    w[TX_SUMMARY_BIT]  = tx_bit;
    return w;
  endfunction

  // address phase decode
  wire       addr_take = hsel & hready & htrans[1];
  wire       wr_take   = addr_take & hwrite;
  wire       rd_take   = addr_take & ~hwrite;
  wire [7:0] a_ofs     = haddr[7:0];

  // data phase write strobes
  wire w_tx_ev_set  = wr_hit(wr_pend_q, wr_addr_q, TX_EVENT_SET_OFS);
  wire w_tx_ev_clr  = wr_hit(wr_pend_q, wr_addr_q, TX_EVENT_CLEAR_OFS);
  wire w_tx_mk_set  = wr_hit(wr_pend_q, wr_addr_q, TX_MASK_SET_OFS);
  wire w_tx_mk_clr  = wr_hit(wr_pend_q, wr_addr_q, TX_MASK_CLEAR_OFS);
  wire w_rx_ev_set  = wr_hit(wr_pend_q, wr_addr_q, RX_EVENT_SET_OFS);
  wire w_rx_ev_clr  = wr_hit(wr_pend_q, wr_addr_q, RX_EVENT_CLEAR_OFS);
  wire w_rx_mk_set  = wr_hit(wr_pend_q, wr_addr_q, RX_MASK_SET_OFS);
  wire w_rx_mk_clr  = wr_hit(wr_pend_q, wr_addr_q, RX_MASK_CLEAR_OFS);
  wire w_ctrl       = wr_hit(wr_pend_q, wr_addr_q, SUMMARY_CTRL_OFS);

  // rising edges of the per-context completion lines
  wire [TX_CTX_N-1:0] tx_rise = tx_ctx_irq & ~tx_line_q;
  wire [RX_CTX_N-1:0] rx_rise = rx_ctx_irq & ~rx_line_q;

  wire [TX_CTX_N-1:0] tx_set_v = w_tx_ev_set ? hwdata[TX_CTX_N-1:0] : '0;
  wire [TX_CTX_N-1:0] tx_clr_v = w_tx_ev_clr ? hwdata[TX_CTX_N-1:0] : '0;
  wire [RX_CTX_N-1:0] rx_set_v = w_rx_ev_set ? hwdata[RX_CTX_N-1:0] : '0;
  wire [RX_CTX_N-1:0] rx_clr_v = w_rx_ev_clr ? hwdata[RX_CTX_N-1:0] : '0;
  wire [TX_CTX_N-1:0] tx_mk_set_v = w_tx_mk_set ? hwdata[TX_CTX_N-1:0] : '0;
  wire [TX_CTX_N-1:0] tx_mk_clr_v = w_tx_mk_clr ? hwdata[TX_CTX_N-1:0] : '0;
  wire [RX_CTX_N-1:0] rx_mk_set_v = w_rx_mk_set ? hwdata[RX_CTX_N-1:0] : '0;
  wire [RX_CTX_N-1:0] rx_mk_clr_v = w_rx_mk_clr ? hwdata[RX_CTX_N-1:0] : '0;

  // a new edge in the same cycle as a clear keeps the bit set
  assign tx_event_d = tx_w1_update(tx_event_q, tx_set_v | tx_rise, tx_clr_v);
  assign rx_event_d = rx_w1_update(rx_event_q, rx_set_v | rx_rise, rx_clr_v);

  // set and clear offsets differ, so a mask write is only ever one or the other
  assign tx_mask_d = tx_w1_update(tx_mask_q, tx_mk_set_v, tx_mk_clr_v);
  assign rx_mask_d = rx_w1_update(rx_mask_q, rx_mk_set_v, rx_mk_clr_v);

  assign gate_d      = w_ctrl ? hwdata[GLOBAL_GATE_BIT] : gate_q;
  assign tx_sum_en_d = w_ctrl ? hwdata[TX_SUMMARY_BIT] : tx_sum_en_q;
  assign rx_sum_en_d = w_ctrl ? hwdata[RX_SUMMARY_BIT] : rx_sum_en_q;

  wire [TX_CTX_N-1:0] tx_masked = tx_event_q & tx_mask_q;
  wire [RX_CTX_N-1:0] rx_masked = rx_event_q & rx_mask_q;

  assign tx_summary_irq = |tx_masked;
  assign rx_summary_irq = |rx_masked;

  // summary bits feed the single output only through their masks and gate
  assign irq = gate_q & ((tx_summary_irq & tx_sum_en_q) |
                         (rx_summary_irq & rx_sum_en_q));

  // read views, zero-extended so the unused upper bits always read zero
  wire [31:0] tx_event_view  = {{(32-TX_CTX_N){1'b0}}, tx_event_q};
  wire [31:0] tx_masked_view = {{(32-TX_CTX_N){1'b0}}, tx_masked};
  wire [31:0] tx_mask_view   = {{(32-TX_CTX_N){1'b0}}, tx_mask_q};
  wire [31:0] rx_event_view  = {{(32-RX_CTX_N){1'b0}}, rx_event_q};
  wire [31:0] rx_masked_view = {{(32-RX_CTX_N){1'b0}}, rx_masked};
  wire [31:0] rx_mask_view   = {{(32-RX_CTX_N){1'b0}}, rx_mask_q};
  wire [31:0] ctrl_view      = summary_word(gate_q, rx_sum_en_q, tx_sum_en_q);
  // status word: raw summaries, read only
  wire [31:0] stat_view      = summary_word(1'b0, rx_summary_irq, tx_summary_irq);

  // read mux, evaluated in the address phase; unmapped reads return zero
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    if (a_ofs == TX_EVENT_SET_OFS)
      rd_mux = tx_event_view;
    else if (a_ofs == TX_EVENT_CLEAR_OFS)
      rd_mux = tx_masked_view;
    else if (a_ofs == TX_MASK_SET_OFS || a_ofs == TX_MASK_CLEAR_OFS)
      rd_mux = tx_mask_view;
    else if (a_ofs == RX_EVENT_SET_OFS)
      rd_mux = rx_event_view;
    else if (a_ofs == RX_EVENT_CLEAR_OFS)
      rd_mux = rx_masked_view;
    else if (a_ofs == RX_MASK_SET_OFS || a_ofs == RX_MASK_CLEAR_OFS)
      rd_mux = rx_mask_view;
    else if (a_ofs == SUMMARY_CTRL_OFS)
      rd_mux = ctrl_view;
    else if (a_ofs == SUMMARY_STAT_OFS)
      rd_mux = stat_view;
  end

  // sticky transmit context events
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_event_q <= TX_EVENT_RST;
    end
    else
    begin
      tx_event_q <= tx_event_d;
    end
  end

  // sticky receive context events
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_event_q <= RX_EVENT_RST;
    end
    else
    begin
      rx_event_q <= rx_event_d;
    end
  end

  // transmit context masks
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_mask_q <= TX_MASK_RST;
    end
    else
    begin
      tx_mask_q <= tx_mask_d;
    end
  end

  // receive context masks
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_mask_q <= RX_MASK_RST;
    end
    else
    begin
      rx_mask_q <= rx_mask_d;
    end
  end

  // last transmit line levels; reset to the idle level so a line still low at reset release gives no edge
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_line_q <= '0;
    end
    else
    begin
      tx_line_q <= tx_ctx_irq;
    end
  end

  // last receive line levels
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_line_q <= '0;
    end
    else
    begin
      rx_line_q <= rx_ctx_irq;
    end
  end

  // global interrupt gate
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      gate_q <= CTRL_RST[GLOBAL_GATE_BIT];
    end
    else
    begin
      gate_q <= gate_d;
    end
  end

  // transmit summary enable
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      tx_sum_en_q <= CTRL_RST[TX_SUMMARY_BIT];
    end
    else
    begin
      tx_sum_en_q <= tx_sum_en_d;
    end
  end

  // receive summary enable
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rx_sum_en_q <= CTRL_RST[RX_SUMMARY_BIT];
    end
    else
    begin
      rx_sum_en_q <= rx_sum_en_d;
    end
  end

  // write pending: hwdata only stands in the cycle after the address phase
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_pend_q <= 1'b0;
    end
    else
    begin
      wr_pend_q <= wr_take;
    end
  end

  // offset of the transfer now in its data phase
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_addr_q <= 8'h00;
    end
    else if (addr_take)
    begin
      wr_addr_q <= a_ofs;
    end
  end

  // read data registered in the address phase and held until the next read
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      hrdata_q <= 32'h0000_0000;
    end
    else if (rd_take)
    begin
      hrdata_q <= rd_mux;
    end
  end

  assign hrdata    = hrdata_q;
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;

endmodule // iso_context_irq_event_mask

// *** iso_irq_sva.sv ***
// iso_irq_sva: port-level checker for the context event/mask block.
// assumes hready is fed back from hreadyout by the bus fabric.
`timescale 1ns/10ps
module iso_irq_sva
  import iso_irq_pkg::*;
(
  input wire logic        clk,            // clock
  input wire logic        arst_n,         // reset
  input wire logic        hsel,           // select
  input wire logic [31:0] haddr,          // address
  input wire logic [1:0]  htrans,         // type
  input wire logic        hwrite,         // write
  input wire logic [2:0]  hsize,          // size
  input wire logic [31:0] hwdata,         // wdata
  input wire logic        hready,         // ready in
  input wire logic [31:0] hrdata,         // rdata
  input wire logic        hreadyout,      // ready out
  input wire logic        hresp,          // resp
  input wire logic [7:0]  tx_ctx_irq,     // tx lines
  input wire logic [3:0]  rx_ctx_irq,     // rx lines
  input wire logic        tx_summary_irq, // tx sum
  input wire logic        rx_summary_irq, // rx sum
  input wire logic        irq             // irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!arst_n);
  logic wr;
  logic rd;
  // the state only moves two edges after a write address is taken
  assign wr = hsel & hready & htrans[1] & hwrite;
  assign rd = hsel & hready & htrans[1] & ~hwrite;
  a_tx_rise: assert property ($rose(tx_summary_irq) |-> $past(wr, 2) ||
    |($past(tx_ctx_irq) & ~$past(tx_ctx_irq, 2))) else $error("tx summary rose without cause");
  a_rx_rise: assert property ($rose(rx_summary_irq) |-> $past(wr, 2) ||
    |($past(rx_ctx_irq) & ~$past(rx_ctx_irq, 2))) else $error("rx summary rose without cause");
  a_tx_fall: assert property ($fell(tx_summary_irq) |-> $past(wr, 2))
    else $error("tx summary fell without a write");
  a_rx_fall: assert property ($fell(rx_summary_irq) |-> $past(wr, 2))
    else $error("rx summary fell without a write");
  a_irq_src: assert property (irq |-> tx_summary_irq || rx_summary_irq)
    else $error("irq without summary");
  a_irq_rise: assert property ($rose(irq) |-> $rose(tx_summary_irq) ||
    $rose(rx_summary_irq) || $past(wr, 2)) else $error("irq rose without cause");
  a_tx_upper: assert property ($past(rd && haddr[7:0] == TX_EVENT_SET_OFS)
    |-> hrdata[31:8] == 24'h0) else $error("tx event upper bits set");
  a_rx_upper: assert property ($past(rd && haddr[7:0] == RX_EVENT_SET_OFS)
    |-> hrdata[31:4] == 28'h0) else $error("rx event upper bits set");
  a_tx_masked: assert property ($past(rd && haddr[7:0] == TX_EVENT_CLEAR_OFS)
    |-> (hrdata != 32'h0) == $past(tx_summary_irq)) else $error("tx masked view wrong");
  a_rx_masked: assert property ($past(rd && haddr[7:0] == RX_EVENT_CLEAR_OFS)
    |-> (hrdata != 32'h0) == $past(rx_summary_irq)) else $error("rx masked view wrong");
  a_bus_okay: assert property (hreadyout && !hresp)
    else $error("bus not ready or not okay");
  cover property ($rose(irq));
  cover property ($fell(tx_summary_irq));
  cover property ($rose(rx_summary_irq));
endmodule // iso_irq_sva

bind iso_context_irq_event_mask iso_irq_sva u_sva (.clk, .arst_n, .hsel, .haddr, .htrans,
  .hwrite, .hsize, .hwdata, .hready, .hrdata, .hreadyout, .hresp, .tx_ctx_irq, .rx_ctx_irq,
  .tx_summary_irq, .rx_summary_irq, .irq);

// *** testbench.sv ***
// testbench: register-level scenarios for the context event/mask block.
// assumes one AHB-Lite master with hready fed back from hreadyout.
`timescale 1ns/10ps
module testbench;
  import iso_irq_pkg::*;
  logic        clk = 0, arst_n = 0, hsel = 0, hwrite = 0;
  logic [31:0] haddr = 0, hwdata = 0, hrdata, q;
  logic [1:0]  htrans = 0;
  logic [2:0]  hsize = HSIZE_WORD;
  logic [7:0]  tx_ctx_irq = 0;
  logic [3:0]  rx_ctx_irq = 0;
  logic        hreadyout, hresp, tx_summary_irq, rx_summary_irq, irq;
  int          errors = 0, check_count = 0, cyc = 0;
  always #4 clk = ~clk;
  iso_context_irq_event_mask dut (.clk, .arst_n, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready(hreadyout), .hrdata, .hreadyout, .hresp, .tx_ctx_irq, .rx_ctx_irq,
    .tx_summary_irq, .rx_summary_irq, .irq);
  task report_and_stop;
    $display("checks %0d errors %0d", check_count, errors);
    if (errors == 0 && check_count > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      errors++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // one whole bus cycle; the entry edge leaves an idle cycle between transfers
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'b00;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task rdc(input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(q, e);
  endtask
  task pchk(input logic [2:0] e);
    @(negedge clk);
    chk({27'h0, hreadyout, hresp, irq, tx_summary_irq, rx_summary_irq}, {27'h0, 2'b10, e});
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 3000)
    begin
      errors++;
      report_and_stop;
    end
  end
  initial
  begin
    repeat (5) @(posedge clk);
    arst_n <= 1'b1;
    pchk(3'b000);
    rdc(TX_MASK_SET_OFS, 32'h0);
    rdc(8'h50, 32'h0);
    @(posedge clk) tx_ctx_irq <= 8'h81;
    rdc(TX_EVENT_SET_OFS, 32'h81);
    xfer(1'b1, TX_EVENT_CLEAR_OFS, 32'h81);
    rdc(TX_EVENT_SET_OFS, 32'h0);
    @(posedge clk) tx_ctx_irq <= 8'h00;
    xfer(1'b1, TX_EVENT_SET_OFS, 32'hffff_ff24);
    rdc(TX_EVENT_SET_OFS, 32'h24);
    xfer(1'b1, TX_EVENT_CLEAR_OFS, 32'h0);
    rdc(TX_EVENT_SET_OFS, 32'h24);
    xfer(1'b1, TX_MASK_SET_OFS, 32'h0c);
    rdc(TX_MASK_CLEAR_OFS, 32'h0c);
    rdc(TX_EVENT_CLEAR_OFS, 32'h04);
    pchk(3'b010);
    rdc(SUMMARY_STAT_OFS, 32'h40);
    xfer(1'b1, SUMMARY_CTRL_OFS, 32'h40);
    pchk(3'b010);
    xfer(1'b1, SUMMARY_CTRL_OFS, 32'h8000_0000);
    pchk(3'b010);
    xfer(1'b1, SUMMARY_CTRL_OFS, 32'h8000_00c0);
    pchk(3'b110);
    xfer(1'b1, TX_MASK_CLEAR_OFS, 32'h04);
    pchk(3'b000);
    rdc(TX_MASK_SET_OFS, 32'h08);
    @(posedge clk) rx_ctx_irq <= 4'ha;
    @(posedge clk) rx_ctx_irq <= 4'h0;
    rdc(RX_EVENT_SET_OFS, 32'ha);
    xfer(1'b1, RX_MASK_SET_OFS, 32'hffff_ffff);
    rdc(RX_EVENT_CLEAR_OFS, 32'ha);
    pchk(3'b101);
    rdc(SUMMARY_STAT_OFS, 32'h80);
    xfer(1'b1, RX_EVENT_CLEAR_OFS, 32'h2);
    rdc(RX_EVENT_SET_OFS, 32'h8);
    xfer(1'b1, RX_EVENT_CLEAR_OFS, 32'h8);
    pchk(3'b000);
    xfer(1'b1, RX_EVENT_SET_OFS, 32'hffff_fff0);
    rdc(RX_EVENT_SET_OFS, 32'h0);
    xfer(1'b1, RX_EVENT_SET_OFS, 32'h6);
    xfer(1'b1, RX_MASK_CLEAR_OFS, 32'h5);
    rdc(RX_MASK_SET_OFS, 32'ha);
    rdc(RX_EVENT_SET_OFS, 32'h6);
    rdc(RX_EVENT_CLEAR_OFS, 32'h2);
    pchk(3'b101);
    // a context edge lands in the same cycle as the clear of its bit
    fork
      xfer(1'b1, TX_EVENT_CLEAR_OFS, 32'h20);
      begin
        repeat (2) @(posedge clk);
        tx_ctx_irq <= 8'h20;
      end
    join
    rdc(TX_EVENT_SET_OFS, 32'h24);
    @(posedge clk) tx_ctx_irq <= 8'h00;
    report_and_stop;
  end
endmodule // testbench
